// ---- include/pri_defines.svh ----
`ifndef PRI_DEFINES_SVH
`define PRI_DEFINES_SVH

// byte offsets inside the peripheral window
`define PRI_OFF_CTRL     14'h0000
`define PRI_OFF_MODE     14'h0004
`define PRI_OFF_ENA      14'h0008
`define PRI_OFF_DIS      14'h000C
`define PRI_OFF_ENSTAT   14'h0010
`define PRI_OFF_STATUS   14'h0014
`define PRI_OFF_IER      14'h0018
`define PRI_OFF_IDR      14'h001C
`define PRI_OFF_IMR      14'h0020
`define PRI_OFF_RXDATA   14'h0024
`define PRI_OFF_TXDATA   14'h0028
`define PRI_OFF_CH_BASE  14'h0030
`define PRI_CH_STRIDE    14'h0008
`define PRI_CH_CNT_OFF   14'h0004

// field positions
`define PRI_STAT_END_LSB 0
`define PRI_STAT_EXT_LSB 4
`define PRI_CTRL_ABT_LSB 0

// reset values
`define PRI_MODE_RST     16'h0000
`define PRI_ENSTAT_RST   16'h0000
`define PRI_IMR_RST      16'h0000
`define PRI_PTR_RST      32'h0000_0000
`define PRI_CNT_RST      16'h0000

// window sizes in address bits
`define PRI_WIN_BITS     14
`define PRI_WIN_BITS_IRQ 12

`endif

// ---- include/pri_pkg.sv ----
package pri_pkg;
  typedef logic [31:0] pri_word_t;
  typedef logic [15:0] pri_count_t;
  typedef logic [13:0] pri_off_t;
  // channel roles: two serial ports, one receive and one transmit channel each
  typedef enum logic [1:0] {
    PRI_CH_RX0,
    PRI_CH_TX0,
    PRI_CH_RX1,
    PRI_CH_TX1
  } pri_chan_t;
endpackage : pri_pkg

// ---- src/pri_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pri_defines.svh"

module pri_regs
  import pri_pkg::*;
#(
  parameter int        WIN_BITS   = `PRI_WIN_BITS,
  parameter pri_word_t WIN_BASE   = 32'hFFFC_0000,
  parameter int        MODE_W     = 16,
  parameter int        ENS_W      = 16,
  parameter int        EXT_W      = 12,
  parameter int        CMD_W      = 8,
  parameter int        XFER_BYTES = 1
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire pri_word_t        paddr,
  input  wire pri_word_t        pwdata,
  output var  pri_word_t        prdata,
  output logic                  pready,
  output logic                  pslverr,
  output var  logic [CMD_W-1:0] cmd_pulse,
  output var  logic [MODE_W-1:0] mode,
  output var  logic [ENS_W-1:0] enable_state,
  input  wire logic [EXT_W-1:0] periph_status,
  input  wire logic             rx_data_valid,
  input  wire pri_word_t        rx_data_in,
  output var  pri_word_t        tx_data,
  output logic                  tx_data_wr,
  input  wire logic [3:0]       xfer_done,
  output var  logic [3:0]       chan_busy,
  output var  pri_word_t        chan_ptr [4],
  output logic                  irq_source
);

  localparam int STAT_W = EXT_W + 4;

  function automatic logic hit(input pri_off_t off, input pri_off_t reg_off);
    return off == reg_off;
  endfunction : hit

  pri_off_t          loc_off;
  logic              in_win;
  logic              acc;
  logic              wr;
  logic              rd;
  logic [3:0]        end_flags;
  logic [STAT_W-1:0] status;
  pri_count_t        chan_cnt [4];
  logic [3:0]        ptr_wr;
  logic [3:0]        cnt_wr;
  logic [3:0]        abort;

  logic [CMD_W-1:0]  cmd_ff;
  logic [MODE_W-1:0] mode_ff;
  logic [ENS_W-1:0]  ens_ff;
  logic [STAT_W-1:0] imr_ff;
  pri_word_t         rxd_ff;
  pri_word_t         txd_ff;
  logic              txw_ff;
  pri_word_t         rdata_ff;
  logic [CMD_W-1:0]  nxt_cmd;
  logic [MODE_W-1:0] nxt_mode;
  logic [ENS_W-1:0]  nxt_ens;
  logic [STAT_W-1:0] nxt_imr;
  pri_word_t         nxt_rdata;

  // low two address bits are dropped, so any byte or half-word hit is a word access
  assign loc_off = pri_off_t'(paddr[WIN_BITS-1:0]) & ~14'h0003;
  assign in_win  = (paddr[31:WIN_BITS] == WIN_BASE[31:WIN_BITS]);
  assign acc     = psel && penable && in_win;
  assign wr      = acc && pwrite;
  assign rd      = psel && !penable && !pwrite && in_win;
  // zero wait states, no errors: an unmapped offset reads zero and drops writes
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  assign nxt_cmd  = (wr && hit(loc_off, `PRI_OFF_CTRL)) ? pwdata[CMD_W-1:0] : '0;
  assign nxt_mode = (wr && hit(loc_off, `PRI_OFF_MODE)) ? pwdata[MODE_W-1:0] : mode_ff;
  assign nxt_ens  = (wr && hit(loc_off, `PRI_OFF_ENA)) ? (ens_ff | pwdata[ENS_W-1:0]) :
                    (wr && hit(loc_off, `PRI_OFF_DIS)) ? (ens_ff & ~pwdata[ENS_W-1:0]) :
                    ens_ff;
  assign nxt_imr  = (wr && hit(loc_off, `PRI_OFF_IER)) ? (imr_ff | pwdata[STAT_W-1:0]) :
                    (wr && hit(loc_off, `PRI_OFF_IDR)) ? (imr_ff & ~pwdata[STAT_W-1:0]) :
                    imr_ff;

  // status is pure hardware state; its offset has no write path at all
  assign status = {periph_status, end_flags};
  assign abort  = (wr && hit(loc_off, `PRI_OFF_CTRL)) ?
                  pwdata[`PRI_CTRL_ABT_LSB +: 4] : 4'h0;

  for (genvar i = 0; i < 4; i++) begin : g_chan
    localparam pri_off_t PTR_OFF = `PRI_OFF_CH_BASE + pri_off_t'(i) * `PRI_CH_STRIDE;
    assign ptr_wr[i] = wr && hit(loc_off, PTR_OFF);
    assign cnt_wr[i] = wr && hit(loc_off, PTR_OFF + `PRI_CH_CNT_OFF);
    pri_xfer_channel #(
      .XFER_BYTES(XFER_BYTES)
    ) u_chan (
      .mclk     (mclk),
      .nrst     (nrst),
      .ptr_wr   (ptr_wr[i]),
      .cnt_wr   (cnt_wr[i]),
      .abort    (abort[i]),
      .wdata    (pwdata),
      .xfer_done(xfer_done[i]),
      .ptr      (chan_ptr[i]),
      .cnt      (chan_cnt[i]),
      .busy     (chan_busy[i]),
      .end_flag (end_flags[i])
    );
  end

  // read data is registered in the setup phase and stands during the access phase
  always_comb begin
    nxt_rdata = '0;
    if (hit(loc_off, `PRI_OFF_MODE)) begin
      nxt_rdata = 32'(mode_ff);
    end
    if (hit(loc_off, `PRI_OFF_ENSTAT)) begin
      nxt_rdata = 32'(ens_ff);
    end
    if (hit(loc_off, `PRI_OFF_STATUS)) begin
      nxt_rdata = 32'(status);
    end
    if (hit(loc_off, `PRI_OFF_IMR)) begin
      nxt_rdata = 32'(imr_ff);
    end
    if (hit(loc_off, `PRI_OFF_RXDATA)) begin
      nxt_rdata = rxd_ff;
    end
    if (hit(loc_off, `PRI_OFF_TXDATA)) begin
      nxt_rdata = txd_ff;
    end
    for (int k = 0; k < 4; k++) begin
      if (hit(loc_off, `PRI_OFF_CH_BASE + pri_off_t'(k) * `PRI_CH_STRIDE)) begin
        nxt_rdata = chan_ptr[k];
      end
      if (hit(loc_off, `PRI_OFF_CH_BASE + pri_off_t'(k) * `PRI_CH_STRIDE + `PRI_CH_CNT_OFF)) begin
        nxt_rdata = 32'(chan_cnt[k]);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cmd_ff   <= '0;
      mode_ff  <= `PRI_MODE_RST;
      ens_ff   <= `PRI_ENSTAT_RST;
      imr_ff   <= `PRI_IMR_RST;
      rxd_ff   <= '0;
      txd_ff   <= '0;
      txw_ff   <= 1'b0;
      rdata_ff <= '0;
    end else begin
      cmd_ff  <= nxt_cmd;
      mode_ff <= nxt_mode;
      ens_ff  <= nxt_ens;
      imr_ff  <= nxt_imr;
      txw_ff  <= wr && hit(loc_off, `PRI_OFF_TXDATA);
      if (rx_data_valid) begin
        rxd_ff <= rx_data_in;
      end
      if (wr && hit(loc_off, `PRI_OFF_TXDATA)) begin
        txd_ff <= pwdata;
      end
      if (rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign cmd_pulse    = cmd_ff;
  assign mode         = mode_ff;
  assign enable_state = ens_ff;
  assign tx_data      = txd_ff;
  assign tx_data_wr   = txw_ff;
  assign prdata       = rdata_ff;
  assign irq_source   = |(status & imr_ff);

  a_enable_sets: assert property (@(posedge mclk) disable iff (!nrst)
    wr && hit(loc_off, `PRI_OFF_ENA) |=> (enable_state & $past(pwdata[ENS_W-1:0]))
      == $past(pwdata[ENS_W-1:0]))
    else $error("enable write did not set status bits");
  a_disable_clears: assert property (@(posedge mclk) disable iff (!nrst)
    wr && hit(loc_off, `PRI_OFF_DIS) |=> (enable_state & $past(pwdata[ENS_W-1:0])) == '0)
    else $error("disable write did not clear status bits");
  a_zero_keeps: assert property (@(posedge mclk) disable iff (!nrst)
    wr && (hit(loc_off, `PRI_OFF_ENA) || hit(loc_off, `PRI_OFF_DIS))
    |=> ((enable_state ^ $past(enable_state)) & ~$past(pwdata[ENS_W-1:0])) == '0)
    else $error("zero bit changed a status bit");
  a_mask_only_cmd: assert property (@(posedge mclk) disable iff (!nrst)
    !(wr && (hit(loc_off, `PRI_OFF_IER) || hit(loc_off, `PRI_OFF_IDR))) |=> $stable(imr_ff))
    else $error("mask changed without enable or disable write");
  a_irq_or: assert property (@(posedge mclk) disable iff (!nrst)
    irq_source == ((status & imr_ff) != '0))
    else $error("interrupt source is not the masked OR");
  a_cmd_pulse: assert property (@(posedge mclk) disable iff (!nrst)
    cmd_pulse != '0 |-> $past(wr && hit(loc_off, `PRI_OFF_CTRL)))
    else $error("command fired without a control write");
  a_mode_reset: assert property (@(posedge mclk)
    $rose(nrst) |-> mode == '0 && imr_ff == '0)
    else $error("mode not zero after reset");
  a_unused_zero: assert property (@(posedge mclk) disable iff (!nrst)
    $past(rd) && $past(hit(loc_off, `PRI_OFF_MODE)) |-> prdata[31:MODE_W] == '0)
    else $error("unused mode bits read nonzero");
  a_word_align: assert property (@(posedge mclk) disable iff (!nrst)
    wr && paddr[1:0] != 2'h0 && hit(loc_off, `PRI_OFF_MODE) |=> mode == $past(pwdata[MODE_W-1:0]))
    else $error("sub-word write not carried out as word");
  a_end_irq: assert property (@(posedge mclk) disable iff (!nrst)
    imr_ff[`PRI_STAT_END_LSB] && end_flags[0] |-> irq_source)
    else $error("masked end of transfer raised no interrupt");
  a_mode_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !(wr && hit(loc_off, `PRI_OFF_MODE)) |=> $stable(mode))
    else $error("mode changed without a mode write");
  a_status_ro: assert property (@(posedge mclk) disable iff (!nrst)
    wr && hit(loc_off, `PRI_OFF_STATUS)
    |=> $stable(mode) && $stable(enable_state) && $stable(imr_ff))
    else $error("status write changed a register");
  // an access just outside the window must not alias onto a register
  a_window_drop: assert property (@(posedge mclk) disable iff (!nrst)
    psel && penable && pwrite && !in_win |=> $stable(mode) && $stable(enable_state))
    else $error("out-of-window write reached a register");
  a_abort_idle: assert property (@(posedge mclk) disable iff (!nrst)
    wr && hit(loc_off, `PRI_OFF_CTRL)
    |=> (chan_busy & $past(pwdata[`PRI_CTRL_ABT_LSB +: 4])) == 4'h0)
    else $error("abort command left a channel busy");
  a_rx_capture: assert property (@(posedge mclk) disable iff (!nrst)
    rx_data_valid |=> rxd_ff == $past(rx_data_in))
    else $error("receive word not captured");
  a_tx_strobe: assert property (@(posedge mclk) disable iff (!nrst)
    wr && hit(loc_off, `PRI_OFF_TXDATA) |=> tx_data_wr && tx_data == $past(pwdata))
    else $error("transmit write gave no strobe or word");

  c_abort_cmd: cover property (@(posedge mclk) disable iff (!nrst)
    wr && hit(loc_off, `PRI_OFF_CTRL) && pwdata[3:0] != 4'h0);
  c_irq_rise: cover property (@(posedge mclk) disable iff (!nrst) $rose(irq_source));
  c_chan_run: cover property (@(posedge mclk) disable iff (!nrst) $fell(chan_busy[1]));
  c_tx_write: cover property (@(posedge mclk) disable iff (!nrst) tx_data_wr);

endmodule : pri_regs
`default_nettype wire

// ---- src/pri_xfer_channel.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pri_defines.svh"

module pri_xfer_channel
  import pri_pkg::*;
#(
  parameter int XFER_BYTES = 1
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       ptr_wr,
  input  wire logic       cnt_wr,
  input  wire logic       abort,
  input  wire pri_word_t  wdata,
  input  wire logic       xfer_done,
  output var  pri_word_t  ptr,
  output var  pri_count_t cnt,
  output logic            busy,
  output logic            end_flag
);

  pri_word_t  ptr_ff;
  pri_count_t cnt_ff;
  pri_word_t  nxt_ptr;
  pri_count_t nxt_cnt;
  logic       step;

  // a done strobe on an idle channel is ignored
  assign step    = xfer_done && (cnt_ff != 16'h0000);
  // software writes win over a transfer completing in the same cycle
  assign nxt_ptr = ptr_wr ? wdata : (step ? ptr_ff + 32'(XFER_BYTES) : ptr_ff);
  assign nxt_cnt = (cnt_wr ? wdata[15:0] :
                   (abort ? 16'h0000 : (step ? cnt_ff - 16'h0001 : cnt_ff)));

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ptr_ff <= `PRI_PTR_RST;
      cnt_ff <= `PRI_CNT_RST;
    end else begin
      ptr_ff <= nxt_ptr;
      cnt_ff <= nxt_cnt;
    end
  end

  assign ptr      = ptr_ff;
  assign cnt      = cnt_ff;
  assign busy     = (cnt_ff != 16'h0000);
  assign end_flag = (cnt_ff == 16'h0000);

  a_ptr_advance: assert property (@(posedge mclk) disable iff (!nrst)
    step && !ptr_wr |=> ptr == $past(ptr) + 32'(XFER_BYTES))
    else $error("pointer did not advance by the transfer size");
  a_cnt_decrement: assert property (@(posedge mclk) disable iff (!nrst)
    step && !cnt_wr && !abort |=> cnt == $past(cnt) - 16'h0001)
    else $error("counter did not decrement on a transfer");
  a_idle_hold: assert property (@(posedge mclk) disable iff (!nrst)
    end_flag && !cnt_wr |=> end_flag && $stable(ptr) || $past(ptr_wr))
    else $error("idle channel moved without a write");
  c_chan_finish: cover property (@(posedge mclk) disable iff (!nrst)
    busy ##1 end_flag);

endmodule : pri_xfer_channel
`default_nettype wire

// ---- testbench/pri_periph_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module pri_periph_model
  import pri_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic [3:0]  run,
  input  wire logic        rx_go,
  input  wire pri_word_t   rx_word,
  input  wire logic [11:0] stat,
  output logic [3:0]       xfer_done,
  output logic             rx_data_valid,
  output pri_word_t        rx_data_in,
  output logic [11:0]      periph_status
);
  // outputs other than rx_data_in settle at the first edge, long before the block leaves reset; rx_data_in stays unknown until the first rx_go
  always @(posedge mclk) begin
    // one completion every cycle while asked, busy or not
    xfer_done <= run;
    rx_data_valid <= rx_go;
    // word is only meaningful with the strobe; scramble it otherwise
    rx_data_in <= rx_go ? rx_word : ~rx_data_in;
    periph_status <= stat;
  end
endmodule : pri_periph_model

`default_nettype wire

// ---- testbench/tb_pri_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pri_defines.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end

module tb_pri_regs
  import pri_pkg::*;
;
  localparam pri_word_t B = 32'hFFFC_0000;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  pri_word_t   paddr = 32'h0000_0000;
  pri_word_t   pwdata = 32'h0000_0000;
  pri_word_t   prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  cmd_pulse;
  logic [15:0] mode;
  logic [15:0] enable_state;
  logic [11:0] periph_status;
  logic        rx_data_valid;
  pri_word_t   rx_data_in;
  pri_word_t   tx_data;
  logic        tx_data_wr;
  logic [3:0]  xfer_done;
  logic [3:0]  chan_busy;
  pri_word_t   chan_ptr [4];
  logic        irq_source;
  logic [3:0]  run = 4'h0;
  logic        rx_go = 1'b0;
  pri_word_t   rx_word = 32'h0000_0000;
  logic [7:0]  cmd_acc = 8'h00;
  int          cmd_n = 0;
  int          tx_n = 0;
  int          fail_count = 0;
  int          compares = 0;
  pri_word_t   cb;

  always #4 mclk = ~mclk;

  pri_regs DUT (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_pulse(cmd_pulse), .mode(mode), .enable_state(enable_state),
    .periph_status(periph_status), .rx_data_valid(rx_data_valid), .rx_data_in(rx_data_in),
    .tx_data(tx_data), .tx_data_wr(tx_data_wr), .xfer_done(xfer_done),
    .chan_busy(chan_busy), .chan_ptr(chan_ptr), .irq_source(irq_source));

  pri_periph_model peer (.mclk(mclk), .run(run), .rx_go(rx_go), .rx_word(rx_word),
    .stat(12'hA5C), .xfer_done(xfer_done), .rx_data_valid(rx_data_valid),
    .rx_data_in(rx_data_in), .periph_status(periph_status));

  // pulses are one cycle wide, so they are collected here rather than polled
  always @(posedge mclk) begin
    // the pulse register is unknown before the first reset edge
    if (!nrst) begin
      cmd_acc <= 8'h00;
    end else begin
      cmd_acc <= cmd_acc | cmd_pulse;
    end
    if (cmd_pulse != 8'h00) cmd_n <= cmd_n + 1;
    if (tx_data_wr === 1'b1) tx_n <= tx_n + 1;
  end

  task automatic acc(input logic w, input pri_word_t a, input pri_word_t d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    // let the access edge settle before anyone looks at the outputs
    #1;
  endtask : acc

  task automatic wr(input pri_word_t a, input pri_word_t d);
    acc(1'b1, a, d);
  endtask : wr

  task automatic chk(input pri_word_t a, input pri_word_t e);
    acc(1'b0, a, 32'h0000_0000);
    `CHK($sformatf("read %h", a), e, prdata)
  endtask : chk

  task automatic results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    results();
  end

  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    chk(B + `PRI_OFF_MODE, 32'h0000_0000);
    chk(B + `PRI_OFF_IMR, 32'h0000_0000);
    chk(B + `PRI_OFF_ENSTAT, 32'h0000_0000);
    chk(B + `PRI_OFF_STATUS, 32'h0000_A5CF);
    `CHK("irq_source", 1'b0, irq_source)
    `CHK("pready", 1'b1, pready)
    `CHK("pslverr", 1'b0, pslverr)
    wr(B + `PRI_OFF_MODE, 32'h0000_A5C3);
    chk(B + 32'h0000_0006, 32'h0000_A5C3);
    wr(B + 32'h0000_0005, 32'h0000_3C5A);
    wr(B + 32'h0001_0004, 32'h0000_1111);
    chk(B + `PRI_OFF_MODE, 32'h0000_3C5A);
    `CHK("mode", 16'h3C5A, mode)
    wr(B + `PRI_OFF_STATUS, 32'h0000_FFFF);
    chk(B + `PRI_OFF_STATUS, 32'h0000_A5CF);
    wr(B + `PRI_OFF_ENA, 32'h0000_00F0);
    wr(B + `PRI_OFF_ENA, 32'h0000_0003);
    chk(B + `PRI_OFF_ENSTAT, 32'h0000_00F3);
    wr(B + `PRI_OFF_DIS, 32'h0000_0030);
    chk(B + `PRI_OFF_ENSTAT, 32'h0000_00C3);
    `CHK("enable_state", 16'h00C3, enable_state)
    wr(B + `PRI_OFF_CTRL, 32'h0000_0080);
    wr(B + `PRI_OFF_CTRL, 32'h0000_0000);
    `CHK("cmd_acc", 8'h80, cmd_acc)
    `CHK("cmd_n", 1, cmd_n)
    chk(B + 32'h0000_002C, 32'h0000_0000);
    wr(B + `PRI_OFF_IER, 32'h0000_0001);
    chk(B + `PRI_OFF_IMR, 32'h0000_0001);
    `CHK("irq_source", 1'b1, irq_source)
    wr(B + `PRI_OFF_IDR, 32'h0000_0001);
    `CHK("irq_source", 1'b0, irq_source)
    wr(B + `PRI_OFF_IER, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      cb = B + 32'h0000_0030 + 32'(8 * i);
      wr(cb, 32'h8000_FF00 | 32'(i));
      wr(cb + 32'h4, 32'h0000_0003);
      `CHK("chan_busy", 1'b1, chan_busy[i])
      `CHK("irq_source", (i != 1), irq_source)
      chk(B + `PRI_OFF_STATUS, 32'h0000_A5CF & ~(32'h1 << i));
      // six completions offered, only three may land
      @(posedge mclk);
      run[i] <= 1'b1;
      repeat (6) @(posedge mclk);
      run <= 4'h0;
      repeat (3) @(posedge mclk);
      chk(cb + 32'h4, 32'h0000_0000);
      chk(cb, 32'h8000_FF03 + 32'(i));
      `CHK("chan_ptr", 32'h8000_FF03 + 32'(i), chan_ptr[i])
      `CHK("irq_source", 1'b1, irq_source)
    end
    wr(B + 32'h0000_0044, 32'h0000_0005);
    wr(B + `PRI_OFF_CTRL, 32'h0000_0004);
    chk(B + 32'h0000_0044, 32'h0000_0000);
    `CHK("cmd_acc", 8'h84, cmd_acc)
    @(posedge mclk);
    rx_word <= 32'hC0DE_5A17;
    rx_go <= 1'b1;
    @(posedge mclk);
    rx_go <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(B + `PRI_OFF_RXDATA, 32'hC0DE_5A17);
    wr(B + `PRI_OFF_TXDATA, 32'h1234_ABCD);
    chk(B + `PRI_OFF_TXDATA, 32'h1234_ABCD);
    `CHK("tx_data", 32'h1234_ABCD, tx_data)
    `CHK("tx_n", 1, tx_n)
    results();
  end
endmodule : tb_pri_regs

`default_nettype wire
